// file: core_status_and_interrupt_control_test.sv
// Purpose: Self-checking bench for the status and interrupt registers.
// Assumes: Core model drives the file port; bench drives events.
// Notes:   Event vector is {ext, tmr, wdt_to, sleep, wdt_clr, por}.
`timescale 1ns/1ps
module core_status_and_interrupt_control_test;
  import csic_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] ev_q = '0;
  logic [3:0] port_hi_i = 4'h0;
  logic periph_irq_i = 1'b0;
  logic c_in = 1'b0;
  logic [7:0] addr, a, b, r, rdata_o, eff_addr_o, result_o;
  logic wr, clr, arith, sub, hit_o, bank_sel_o, irq_o;
  csic_flupd_e flupd;
  int mismatches = 0;
  int n_compared = 0;
  csic_core_model core (.clk_i(clk_i), .addr_o(addr), .wr_o(wr),
    .clr_o(clr), .flupd_o(flupd), .arith_o(arith), .sub_o(sub), .a_o(a),
    .b_o(b), .res_o(r));
  csic_core_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr),
    .wr_i(wr), .clr_file_i(clr), .flupd_i(flupd), .arith_i(arith),
    .sub_i(sub), .opa_i(a), .opb_i(b), .logic_res_i(r), .c_in_i(c_in),
    .por_i(ev_q[0]), .wdt_clr_i(ev_q[1]), .sleep_i(ev_q[2]),
    .wdt_to_i(ev_q[3]), .tmr_ovf_i(ev_q[4]), .ext_irq_i(ev_q[5]),
    .port_hi_i(port_hi_i), .periph_irq_i(periph_irq_i),
    .rdata_o(rdata_o), .hit_o(hit_o), .eff_addr_o(eff_addr_o),
    .result_o(result_o), .bank_sel_o(bank_sel_o), .irq_o(irq_o));
  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;
  // Every compare lands here so mismatches are counted in one place.
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Read after the address settles; check the combinational data.
  task automatic rdchk(input logic [7:0] ad, exp, input string nm);
    core.rd(ad);
    #1;
    check(nm, rdata_o, exp);
  endtask
  // One-cycle event pulse on bit k of the event vector.
  task automatic ev(input int k);
    @(posedge clk_i);
    #1;
    ev_q = 6'h01 << k;
    @(posedge clk_i);
    #1;
    ev_q = '0;
  endtask
  // Reset values, both status aliases.
  task automatic t_reset();
    rdchk(8'h03, 8'h18, "status");
    rdchk(8'h83, 8'h18, "status_alias");
    rdchk(8'h0b, 8'h00, "intctl");
  endtask
  // Plain write: bank bit takes, time-out and power-down do not.
  task automatic t_move();
    core.mv(8'h03, 8'h27);
    check("bank", {7'h00, bank_sel_o}, 8'h01);
    rdchk(8'h83, 8'h3f, "status_wr");
    check("eff", eff_addr_o, 8'h83);
    core.op(8'h03, 1'b1, 1'b1, CSIC_FL_Z, 2'b00, 8'h00, 8'h00, 8'h00);
    rdchk(8'h03, 8'h1f, "clear_file");
  endtask
  // Arithmetic flags replace written data; borrow polarity inverted.
  task automatic t_arith();
    core.op(8'h03, 1'b1, 1'b0, CSIC_FL_ZDCC, 2'b10, 8'h0f, 8'h01, 8'h00);
    check("add_res", result_o, 8'h10);
    rdchk(8'h03, 8'h1a, "add_flags");
    core.op(8'h20, 1'b0, 1'b0, CSIC_FL_ZDCC, 2'b11, 8'h10, 8'h01, 8'h00);
    check("sub_res", result_o, 8'h0f);
    rdchk(8'h03, 8'h19, "sub_nb");
    core.op(8'h20, 1'b0, 1'b0, CSIC_FL_ZDCC, 2'b11, 8'h00, 8'h01, 8'h00);
    rdchk(8'h03, 8'h18, "sub_borrow");
    core.op(8'h20, 1'b0, 1'b0, CSIC_FL_Z, 2'b00, 8'h00, 8'h00, 8'h00);
    rdchk(8'h03, 8'h1c, "zero");
    // A carry-class write to status keeps its data off the flag bits.
    @(posedge clk_i);
    #1;
    c_in = 1'b1;
    core.op(8'h03, 1'b1, 1'b0, CSIC_FL_C, 2'b00, 8'h00, 8'h00, 8'h00);
    rdchk(8'h03, 8'h1d, "carry_in");
  endtask
  // Reset-cause events move time-out and power-down; writes do not.
  task automatic t_events();
    ev(2);
    rdchk(8'h03, 8'h15, "sleep");
    ev(3);
    rdchk(8'h03, 8'h05, "wdt_to");
    ev(0);
    rdchk(8'h03, 8'h1d, "power_up");
    ev(2);
    rdchk(8'h03, 8'h15, "sleep_again");
    core.mv(8'h03, 8'h1d);
    rdchk(8'h03, 8'h15, "pd_ro");
    ev(1);
    rdchk(8'h03, 8'h1d, "wdt_clr");
  endtask
  // Flags set whatever the enables; enables gate the request.
  task automatic t_irq();
    core.mv(8'h0b, 8'hb8);
    check("irq_idle", {7'h00, irq_o}, 8'h00);
    ev(4);
    rdchk(8'h0b, 8'hbc, "tmr_flag");
    check("irq_tmr", {7'h00, irq_o}, 8'h01);
    core.mv(8'h0b, 8'h00);
    ev(5);
    port_hi_i = 4'h8;
    periph_irq_i = 1'b1;
    rdchk(8'h0b, 8'h03, "masked_flags");
    core.mv(8'h0b, 8'hc0);
    check("irq_per", {7'h00, irq_o}, 8'h01);
    core.mv(8'h0b, 8'h80);
    check("irq_noper", {7'h00, irq_o}, 8'h00);
    core.mv(8'h0b, 8'h92);
    check("irq_ext", {7'h00, irq_o}, 8'h01);
    core.mv(8'h0b, 8'h82);
    check("irq_extoff", {7'h00, irq_o}, 8'h00);
  endtask
  // Unimplemented reads zero; indirect location goes via the pointer.
  task automatic t_map();
    rdchk(8'h07, 8'h00, "unimpl");
    check("hit", {7'h00, hit_o}, 8'h00);
    core.mv(8'h04, 8'h8b);
    core.rd(8'h00);
    #1;
    check("indirect", eff_addr_o, 8'h8b);
    check("ind_data", rdata_o, 8'h82);
    check("ind_hit", {7'h00, hit_o}, 8'h01);
  endtask
  // Verdict and end of run, shared with the watchdog.
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A hang would otherwise stall the run; the tests need about 0.7 us.
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
  // Reset for four cycles, then the scenarios in order.
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_move();
    t_arith();
    t_events();
    t_irq();
    t_map();
    complete_run();
  end
endmodule

// file: csic_cfg.svh
// Purpose: Offsets, field positions and reset values for the core status
//          and interrupt control block.
// Assumes: Eight-bit data memory addresses with bank bit in address bit 7.
// Notes:   Definitions only.
`ifndef CSIC_CFG_SVH
`define CSIC_CFG_SVH
`define CSIC_ADDR_W 8
`define CSIC_OFS_INDIRECT 7'h00
`define CSIC_OFS_STATUS 7'h03
`define CSIC_OFS_FSEL 7'h04
`define CSIC_OFS_INTCTL 7'h0b
`define CSIC_BIT_IRP 7
`define CSIC_BIT_RPH 6
`define CSIC_BIT_RPL 5
`define CSIC_BIT_TO 4
`define CSIC_BIT_PD 3
`define CSIC_BIT_Z 2
`define CSIC_BIT_DC 1
`define CSIC_BIT_C 0
`define CSIC_BIT_GIE 7
`define CSIC_BIT_PERIPHERAL_IRQ_ENABLE 6
`define CSIC_BIT_TIMER_OVERFLOW_ENABLE 5
`define CSIC_BIT_EXIE 4
`define CSIC_BIT_PORT_CHANGE_ENABLE 3
`define CSIC_BIT_TIMER_OVERFLOW_FLAG 2
`define CSIC_BIT_EXIF 1
`define CSIC_BIT_PORT_CHANGE_FLAG 0
`define CSIC_STATUS_RST 8'h18
`define CSIC_INTCTL_RST 8'h00
`define CSIC_FSEL_RST 8'h00
`endif

// file: csic_core_model.sv
// Purpose: Core datapath model that issues file register instructions.
// Assumes: Requests change 1 ns after a rising edge and hold one cycle.
// Notes:   Operands stay put after an op, so result_o can be inspected.
`timescale 1ns/1ps
module csic_core_model
  import csic_pkg::*;
(
  input wire logic clk_i,      // Instruction clock.
  output logic [7:0] addr_o,   // File address.
  output logic wr_o,           // Write strobe.
  output logic clr_o,          // Clear-file qualifier.
  output csic_flupd_e flupd_o, // Flag update class.
  output logic arith_o,        // Add or subtract.
  output logic sub_o,          // Subtract.
  output logic [7:0] a_o,      // File operand.
  output logic [7:0] b_o,      // Working operand.
  output logic [7:0] res_o     // Logic result.
);
  // Idle means no write and no flag update, so status is left alone.
  initial begin
    {addr_o, wr_o, clr_o, arith_o, sub_o, a_o, b_o, res_o} = '0;
    flupd_o = CSIC_FL_NONE;
  end
  // One instruction for one cycle; write and flag class then drop.
  task automatic op(input logic [7:0] ad, input logic w, input logic c,
      input csic_flupd_e f, input logic [1:0] as, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] r);
    @(posedge clk_i);
    #1;
    {addr_o, wr_o, clr_o, arith_o, sub_o, a_o, b_o, res_o} =
      {ad, w, c, as, a, b, r};
    flupd_o = f;
    @(posedge clk_i);
    #1;
    {wr_o, clr_o} = 2'b00;
    flupd_o = CSIC_FL_NONE;
  endtask
  // Move from working updates no flags; a move to status writes zero, dc, carry from the data.
  task automatic mv(input logic [7:0] ad, input logic [7:0] r);
    op(ad, 1'b1, 1'b0, CSIC_FL_NONE, 2'b00, 8'h00, 8'h00, r);
  endtask
  // A read only presents the address; data is combinational.
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_i);
    #1;
    addr_o = ad;
  endtask
endmodule

// file: csic_core_regs.sv
// Contract
// - Status register is any instruction's destination.
// - Flag-updating writes replace zero, dc, carry.
// - Time-out and power-down flags are read-only.
// - Clear-file zeroes top three, sets zero.
// - Subtract carry flags mean no borrow.
// - Digit carry reflects carry out of nibble.
// - Status decoded at 03h and 83h.
// - Unimplemented locations read as zero.
// - Indirect location redirects through the pointer.
// - Interrupt control register fully read/write.
// - Flags set regardless of enables.
// - Timer rollover sets its flag.
// - Upper port pin change sets its flag.
// - External enable gates the pin interrupt.
//
// Purpose: Status, file select pointer and interrupt control registers
//          on the core's file register port.
// Assumes: One register access per clock; write is a one-cycle strobe.
// Notes:   Other file locations are decoded elsewhere; this block
//          answers zero and flags the hit as not its own.
`timescale 1ns/1ps
`include "csic_cfg.svh"
module csic_core_regs
  import csic_pkg::*;
(
  input wire logic clk_i,            // Instruction clock.
  input wire logic rst_n_i,          // Synchronous reset, active low.
  input wire logic [7:0] addr_i,     // Direct file address; bit 7 unused, bank comes from status.
  input wire logic wr_i,             // Write the result to the file.
  input wire logic clr_file_i,       // Write is the clear-file instruction.
  input wire csic_flupd_e flupd_i,   // Flags the instruction updates.
  input wire logic arith_i,          // Operation is an add or subtract.
  input wire logic sub_i,            // Operation is a subtract.
  input wire logic [7:0] opa_i,      // File operand.
  input wire logic [7:0] opb_i,      // Working register operand.
  input wire logic [7:0] logic_res_i, // Result of other operations.
  input wire logic c_in_i,           // Carry from a rotate when flupd C.
  input wire logic por_i,            // Power-up reset event pulse.
  input wire logic wdt_clr_i,        // Watchdog clear instruction pulse.
  input wire logic sleep_i,          // Sleep instruction pulse.
  input wire logic wdt_to_i,         // Watchdog time-out pulse.
  input wire logic tmr_ovf_i,        // Timer rolled over pulse.
  input wire logic ext_irq_i,        // External pin interrupt edge pulse.
  input wire logic [3:0] port_hi_i,  // Upper four port pins.
  input wire logic periph_irq_i,     // Enabled peripheral request.
  output logic [7:0] rdata_o,        // File read data.
  output logic hit_o,                // Address belongs to this block.
  output logic [7:0] eff_addr_o,     // Resolved full data address.
  output logic [7:0] result_o,       // Operation result for the core.
  output logic bank_sel_o,           // Selected data memory bank.
  output logic irq_o                 // Interrupt request to the core.
);
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] fsel;
    logic [7:0] intctl;
    logic [3:0] port_last;
  } csic_state_s;

  csic_state_s st_reg;
  csic_state_s st_next;
  logic [7:0] eff;
  logic [7:0] res;
  logic z_f;
  logic dc_f;
  logic c_f;
  logic wr_status;
  logic wr_fsel;
  logic wr_intctl;
  logic pin_change;

  // Decode ignores the bank bit so shared registers mirror in both banks.
  function automatic logic is_reg(input logic [7:0] a,
                                  input logic [6:0] ofs);
    is_reg = (a[6:0] == ofs);
  endfunction

  csic_flag_logic u_flags (
    .a_i(opa_i),
    .b_i(opb_i),
    .sub_i(sub_i),
    .arith_i(arith_i),
    .logic_i(logic_res_i),
    .res_o(res),
    .z_o(z_f),
    .dc_o(dc_f),
    .c_o(c_f)
  );

  // The indirect location has no storage; the pointer supplies the
  // address instead.
  always_comb begin
    eff = is_reg(addr_i, `CSIC_OFS_INDIRECT) ? st_reg.fsel :
          {st_reg.status[`CSIC_BIT_RPL], addr_i[6:0]};
  end

  // Write decode follows the resolved address, so indirect writes reach
  // the status register too.
  always_comb begin
    wr_status = wr_i && is_reg(eff, `CSIC_OFS_STATUS);
    wr_fsel = wr_i && is_reg(eff, `CSIC_OFS_FSEL);
    wr_intctl = wr_i && is_reg(eff, `CSIC_OFS_INTCTL);
    pin_change = (port_hi_i != st_reg.port_last);
  end

  // All register updates.  Hardware events are applied after software
  // writes so a set in the same cycle as a clear is not lost.
  always_comb begin
    st_next = st_reg;
    st_next.port_last = port_hi_i;
    if (wr_status) begin
      st_next.status[7:5] = res[7:5];
      if (flupd_i == CSIC_FL_NONE) begin
        st_next.status[2:0] = res[2:0];
      end
      if (clr_file_i) begin
        st_next.status[7:5] = 3'h0;
      end
    end
    // Flag logic wins over data for the three arithmetic bits.
    case (flupd_i)
      CSIC_FL_Z: st_next.status[`CSIC_BIT_Z] = z_f;
      CSIC_FL_ZDCC: begin
        st_next.status[`CSIC_BIT_Z] = z_f;
        st_next.status[`CSIC_BIT_DC] = dc_f;
        st_next.status[`CSIC_BIT_C] = c_f;
      end
      CSIC_FL_C: st_next.status[`CSIC_BIT_C] = c_in_i;
      default: ;
    endcase
    // Time-out and power-down change only on reset-cause events.
    if (wdt_clr_i) begin
      st_next.status[`CSIC_BIT_TO] = 1'b1;
      st_next.status[`CSIC_BIT_PD] = 1'b1;
    end else if (sleep_i) begin
      st_next.status[`CSIC_BIT_TO] = 1'b1;
      st_next.status[`CSIC_BIT_PD] = 1'b0;
    end
    if (wdt_to_i) begin
      st_next.status[`CSIC_BIT_TO] = 1'b0;
    end
    if (por_i) begin
      st_next.status[`CSIC_BIT_TO] = 1'b1;
      st_next.status[`CSIC_BIT_PD] = 1'b1;
    end
    if (wr_fsel) begin
      st_next.fsel = res;
    end
    if (wr_intctl) begin
      st_next.intctl = res;
    end
    if (tmr_ovf_i) begin
      st_next.intctl[`CSIC_BIT_TIMER_OVERFLOW_FLAG] = 1'b1;
    end
    if (ext_irq_i) begin
      st_next.intctl[`CSIC_BIT_EXIF] = 1'b1;
    end
    if (pin_change) begin
      st_next.intctl[`CSIC_BIT_PORT_CHANGE_FLAG] = 1'b1;
    end
  end

  // Single register stage for all state.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg.status <= `CSIC_STATUS_RST;
      st_reg.fsel <= `CSIC_FSEL_RST;
      st_reg.intctl <= `CSIC_INTCTL_RST;
      st_reg.port_last <= 4'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read path; anything unmapped here returns zero.
  always_comb begin
    rdata_o = 8'h00;
    hit_o = 1'b0;
    if (is_reg(eff, `CSIC_OFS_STATUS)) begin
      rdata_o = st_reg.status;
      hit_o = 1'b1;
    end else if (is_reg(eff, `CSIC_OFS_FSEL)) begin
      rdata_o = st_reg.fsel;
      hit_o = 1'b1;
    end else if (is_reg(eff, `CSIC_OFS_INTCTL)) begin
      rdata_o = st_reg.intctl;
      hit_o = 1'b1;
    end else if (is_reg(eff, `CSIC_OFS_INDIRECT)) begin
      hit_o = 1'b1; // Pointer aimed at itself reads zero.
    end
  end

  // Request gating by per-source, peripheral and global enables.
  always_comb begin
    eff_addr_o = eff;
    result_o = res;
    bank_sel_o = st_reg.status[`CSIC_BIT_RPL];
    irq_o = st_reg.intctl[`CSIC_BIT_GIE] && (
      (st_reg.intctl[`CSIC_BIT_TIMER_OVERFLOW_ENABLE] && st_reg.intctl[`CSIC_BIT_TIMER_OVERFLOW_FLAG]) ||
      (st_reg.intctl[`CSIC_BIT_EXIE] &&
       st_reg.intctl[`CSIC_BIT_EXIF]) ||
      (st_reg.intctl[`CSIC_BIT_PORT_CHANGE_ENABLE] && st_reg.intctl[`CSIC_BIT_PORT_CHANGE_FLAG]) ||
      (st_reg.intctl[`CSIC_BIT_PERIPHERAL_IRQ_ENABLE] && periph_irq_i));
  end

  property p_ro_flags;
    @(posedge clk_i) disable iff (!rst_n_i)
      (!por_i && !wdt_clr_i && !sleep_i && !wdt_to_i) |=>
      $stable(st_reg.status[4:3]);
  endproperty
  a_ro_flags: assert property (p_ro_flags)
    else $error("Time-out or power-down changed without event.");

  property p_clear_file_instr;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_status && clr_file_i && flupd_i == CSIC_FL_Z && !por_i) |=>
      (st_reg.status[7:5] == 3'h0 && st_reg.status[2] == 1'b1);
  endproperty
  a_clear_file_instr: assert property (p_clear_file_instr)
    else $error("Clear-file of status gave wrong value.");

  property p_tmr_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      tmr_ovf_i |=> st_reg.intctl[`CSIC_BIT_TIMER_OVERFLOW_FLAG];
  endproperty
  a_tmr_flag: assert property (p_tmr_flag)
    else $error("Timer overflow flag not set.");

  property p_irq_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
      !st_reg.intctl[`CSIC_BIT_GIE] |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("Interrupt raised with global enable clear.");

  // Update checks compare with values sampled one edge earlier, so an
  // attempt that starts inside reset is simply disabled.
  property p_flag_block;
    @(posedge clk_i) disable iff (!rst_n_i)
      (flupd_i == CSIC_FL_ZDCC) |=>
      (st_reg.status[2:0] == {$past(z_f), $past(dc_f), $past(c_f)});
  endproperty
  a_flag_block: assert property (p_flag_block)
    else $error("Arithmetic flags did not follow the flag logic.");

  property p_plain_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wr_status && flupd_i == CSIC_FL_NONE && !clr_file_i) |=>
      (st_reg.status[7:5] == $past(res[7:5]) &&
       st_reg.status[2:0] == $past(res[2:0]));
  endproperty
  a_plain_write: assert property (p_plain_write)
    else $error("Plain status write did not land.");

  property p_port_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      pin_change |=>
      st_reg.intctl[`CSIC_BIT_PORT_CHANGE_FLAG];
  endproperty
  a_port_flag: assert property (p_port_flag)
    else $error("Port change flag not set.");

  property p_ext_flag;
    @(posedge clk_i) disable iff (!rst_n_i)
      ext_irq_i |=>
      st_reg.intctl[`CSIC_BIT_EXIF];
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("External interrupt flag not set.");

  property p_wdt_timeout;
    @(posedge clk_i) disable iff (!rst_n_i)
      (wdt_to_i && !por_i) |=>
      !st_reg.status[`CSIC_BIT_TO];
  endproperty
  a_wdt_timeout: assert property (p_wdt_timeout)
    else $error("Watchdog time-out left the time-out flag set.");

  property p_sleep_pd;
    @(posedge clk_i) disable iff (!rst_n_i)
      (sleep_i && !wdt_clr_i && !por_i) |=>
      !st_reg.status[`CSIC_BIT_PD];
  endproperty
  a_sleep_pd: assert property (p_sleep_pd)
    else $error("Sleep left the power-down flag set.");

  property p_periph_req;
    @(posedge clk_i) disable iff (!rst_n_i)
      (st_reg.intctl[`CSIC_BIT_GIE] && st_reg.intctl[`CSIC_BIT_PERIPHERAL_IRQ_ENABLE] &&
       periph_irq_i) |-> irq_o;
  endproperty
  a_periph_req: assert property (p_periph_req)
    else $error("Enabled peripheral request did not interrupt.");

  property p_unmapped_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      !hit_o |->
      (rdata_o == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("Unmapped location read as nonzero.");
endmodule

// file: csic_flag_logic.sv
// Purpose: Computes result and zero, digit carry and carry flags of an
//          eight-bit add or subtract, and zero of a logic result.
// Assumes: Operands arrive from the core datapath in the same cycle.
// Notes:   Subtract is an add of the two's complement.
`timescale 1ns/1ps
module csic_flag_logic (
  input wire logic [7:0] a_i,     // First operand (file register).
  input wire logic [7:0] b_i,     // Second operand (working register).
  input wire logic sub_i,         // High for a minus b.
  input wire logic arith_i,       // High when an add or subtract is done.
  input wire logic [7:0] logic_i, // Result of a non-arithmetic operation.
  output logic [7:0] res_o,       // Operation result.
  output logic z_o,               // Result is zero.
  output logic dc_o,              // Carry out of the low nibble.
  output logic c_o                // Carry out of bit 7.
);
  logic [7:0] b_eff;
  logic [4:0] lo_sum;
  logic [8:0] full_sum;

  // A borrow appears as a clear carry because subtraction adds the
  // inverted operand plus one; no extra polarity flip is needed.
  always_comb begin
    b_eff = sub_i ? ~b_i : b_i;
    lo_sum = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub_i};
    full_sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, sub_i};
    res_o = arith_i ? full_sum[7:0] : logic_i;
    dc_o = lo_sum[4];
    c_o = full_sum[8];
    z_o = (res_o == 8'h00);
  end
endmodule

// file: csic_pkg.sv
// Purpose: Types shared by the core status and interrupt control block.
// Assumes: Nothing beyond the config header.
// Notes:   Holds the flag update class of the executing instruction.
package csic_pkg;
  // Which arithmetic flags the executing instruction updates.
  typedef enum logic [1:0] {
    CSIC_FL_NONE,
    CSIC_FL_Z,
    CSIC_FL_ZDCC,
    CSIC_FL_C
  } csic_flupd_e;
endpackage
